// File: serial_config_port.v
// Behaviour
// - Shift serial input on rising clock while selected.
// - Commit word on every 24th rising edge.
// - Count 24-clock groups from select fall.
// - Discard trailing bits beyond complete words.
// - Word is 8-bit address plus 16 data.
// - Work at any slow clock, any duty.
// - Readback drives addressed register's 16 bits.
// - Update serial output after falling edges.
// - Readback bit stays writable during readback.
// - Other writes inhibited while readback set.
// - Output driver released unless readback set.
// - Reset pin pulse clears configuration registers.
// - Software reset bit resets then self-clears.
// - All register bits read zero after reset.
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_map.vh"

module serial_config_port #(
	parameter ADDR_W = `ADDR_BITS,
	parameter DATA_W = `DATA_BITS,
	parameter DEPTH = `REG_COUNT
) (
	// System
	input wire clk_sys_in,
	input wire sys_rst_in,
	// Device reset pin, from outside the clock domain
	input wire hw_reset_in,
	// Serial link pins
	input wire serial_select_n_in,
	input wire shift_clk_in,
	input wire config_serial_in,
	output reg config_serial_out,
	output wire config_serial_oe_out,
	// Configuration state seen by the rest of the device
	output wire readback_mode_out,
	output reg [ADDR_W-1:0] wr_addr_out,
	output reg [DATA_W-1:0] wr_data_out,
	output reg wr_strobe_out
);

	// Two-flop synchronisers; first stage read only by second
	reg sel_n_meta_reg;
	reg sel_n_sync_reg;
	reg sck_meta_reg;
	reg sck_sync_reg;
	reg sdi_meta_reg;
	reg sdi_sync_reg;
	reg rst_meta_reg;
	reg rst_sync_reg;
	reg sck_prev_reg;
	reg sel_n_prev_reg;

	reg [DATA_W-1:0] regs_mem [0:DEPTH-1];
	reg [`WORD_BITS-2:0] shift_reg;
	reg [`BIT_CNT_W-1:0] bit_cnt_reg;
	reg [DATA_W-1:0] rd_shift_reg;
	reg readback_reg;
	reg soft_rst_reg;
	reg [ADDR_W:0] clr_idx_reg;
	reg clearing_reg;

	wire sck_rise;
	wire sck_fall;
	wire sel_active;
	wire sel_rise;
	wire [`WORD_BITS-1:0] word_full;
	wire [ADDR_W-1:0] word_addr;
	wire [DATA_W-1:0] word_data;
	wire word_done;
	wire any_reset;

	// Receive phase of the current word, one-hot
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ADDR = 3'b010;
	localparam [2:0] ST_DATA = 3'b100;

	reg [2:0] state_reg;
	reg [2:0] state_next;

	// Readback datapath
	wire [DATA_W-1:0] ctrl_image;
	wire [ADDR_W-1:0] rd_addr;
	wire [DATA_W-1:0] rd_word;
	wire rd_load;
	wire rd_shift_en;

	// True on the count that carries the last address bit
	function addr_last;
		input [`BIT_CNT_W-1:0] cnt;
		begin
			addr_last = (cnt == `ADDR_LAST_CNT);
		end
	endfunction

	// Address of the control register, which is not kept in storage
	function is_ctrl;
		input [ADDR_W-1:0] addr;
		begin
			is_ctrl = (addr == `CTRL_ADDR);
		end
	endfunction

	// Next value of the group counter; wraps after each full word
	function [`BIT_CNT_W-1:0] cnt_step;
		input [`BIT_CNT_W-1:0] cnt;
		begin
			if (cnt == `BIT_CNT_LAST) begin
				cnt_step = {`BIT_CNT_W{1'b0}};
			end else begin
				cnt_step = cnt + {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	endfunction

	// Move the readback word one place towards its MSB
	function [DATA_W-1:0] shift_up;
		input [DATA_W-1:0] word;
		begin
			shift_up = {word[DATA_W-2:0], 1'b0};
		end
	endfunction

	// A sampled edge detector keeps timing independent of duty cycle
	// oversampled clock
	assign sck_rise = sck_sync_reg & ~sck_prev_reg;
	assign sck_fall = ~sck_sync_reg & sck_prev_reg;
	assign sel_active = ~sel_n_sync_reg;
	assign sel_rise = sel_n_sync_reg & ~sel_n_prev_reg;
	assign word_full = {shift_reg, sdi_sync_reg};
	assign word_addr = word_full[`WORD_BITS-1:`DATA_BITS];
	assign word_data = word_full[`DATA_BITS-1:0];
	assign word_done = sel_active & sck_rise & (bit_cnt_reg == `BIT_CNT_LAST);
	assign any_reset = sys_rst_in | rst_sync_reg | soft_rst_reg;
	assign readback_mode_out = readback_reg;
	assign config_serial_oe_out = readback_reg;

	// Control bits are returned live so storage needs only one writer
	assign ctrl_image = {{(DATA_W-2){1'b0}}, readback_reg, soft_rst_reg};
	// The address is complete in the low bits of the word at the 8th edge
	assign rd_addr = word_full[ADDR_W-1:0];
	assign rd_word = is_ctrl(rd_addr) ? ctrl_image : regs_mem[rd_addr];
	// load once the address is known
	assign rd_load = readback_reg & addr_last(bit_cnt_reg);
	// Shifting only in the data phase keeps the falls after the
	// last bit of a word from pushing out stale zeros
	assign rd_shift_en = sck_fall & readback_reg & (state_reg == ST_DATA);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (sel_active) begin
					state_next = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (!sel_active) begin
					state_next = ST_IDLE;
				end else if (sck_rise && addr_last(bit_cnt_reg)) begin
					state_next = ST_DATA;
				end
			end
			ST_DATA: begin
				if (!sel_active) begin
					state_next = ST_IDLE;
				end else if (word_done) begin
					state_next = ST_ADDR;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// select rise returns the phase to idle
	always @(posedge clk_sys_in) begin
		if (any_reset) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sel_n_meta_reg <= 1'b1;
			sel_n_sync_reg <= 1'b1;
			sel_n_prev_reg <= 1'b1;
			sck_meta_reg <= 1'b0;
			sck_sync_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			sdi_meta_reg <= 1'b0;
			sdi_sync_reg <= 1'b0;
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			sel_n_meta_reg <= serial_select_n_in;
			sel_n_sync_reg <= sel_n_meta_reg;
			sel_n_prev_reg <= sel_n_sync_reg;
			sck_meta_reg <= shift_clk_in;
			sck_sync_reg <= sck_meta_reg;
			sck_prev_reg <= sck_sync_reg;
			sdi_meta_reg <= config_serial_in;
			sdi_sync_reg <= sdi_meta_reg;
			rst_meta_reg <= hw_reset_in;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Serial receive, readback shifting and control bits
	always @(posedge clk_sys_in) begin
		wr_strobe_out <= 1'b0;
		if (any_reset) begin
			shift_reg <= {(`WORD_BITS-1){1'b0}};
			bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
			rd_shift_reg <= {DATA_W{1'b0}};
			config_serial_out <= 1'b0;
			readback_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
			wr_addr_out <= {ADDR_W{1'b0}};
			wr_data_out <= {DATA_W{1'b0}};
			wr_strobe_out <= 1'b0;
		end else if (sel_rise | ~sel_active) begin
			shift_reg <= {(`WORD_BITS-1){1'b0}};
			bit_cnt_reg <= {`BIT_CNT_W{1'b0}};
		end else if (sck_rise) begin
			shift_reg <= word_full[`WORD_BITS-2:0];
			bit_cnt_reg <= cnt_step(bit_cnt_reg);
			if (word_done) begin
				if (is_ctrl(word_addr)) begin
					readback_reg <= word_data[`READBACK_BIT];
					soft_rst_reg <= word_data[`SOFT_RESET_BIT];
				end else if (!readback_reg) begin
					wr_addr_out <= word_addr;
					wr_data_out <= word_data;
					wr_strobe_out <= 1'b1;
				end
			end
			if (rd_load) begin
				rd_shift_reg <= rd_word;
			end
		end else if (rd_shift_en) begin
			config_serial_out <= rd_shift_reg[DATA_W-1];
			rd_shift_reg <= shift_up(rd_shift_reg);
		end
	end

	// Register storage; cleared one word per cycle after reset
	always @(posedge clk_sys_in) begin
		if (any_reset) begin
			clearing_reg <= 1'b1;
			clr_idx_reg <= {(ADDR_W+1){1'b0}};
		end else if (clearing_reg) begin
			regs_mem[clr_idx_reg[ADDR_W-1:0]] <= `REG_RESET_VALUE;
			clr_idx_reg <= clr_idx_reg + {{ADDR_W{1'b0}}, 1'b1};
			if (clr_idx_reg == DEPTH - 1) begin
				clearing_reg <= 1'b0;
			end
		end else if (wr_strobe_out) begin
			regs_mem[wr_addr_out] <= wr_data_out;
		end
	end

	// Limitation: storage is swept one word per cycle after any reset,
	// so a write landing within the sweep is dropped and never reaches storage;
	// the controller must wait the sweep out before its first frame.
	// The sweep was chosen over a wide parallel clear to keep storage
	// a plain single-port array.

endmodule // serial_config_port
`default_nettype wire

// File: serial_config_map.vh
`ifndef SERIAL_CONFIG_MAP_VH
`define SERIAL_CONFIG_MAP_VH

// Word layout: address first, then data, MSB first
`define WORD_BITS 24
`define ADDR_BITS 8
`define DATA_BITS 16
`define BIT_CNT_W 5
`define BIT_CNT_LAST 5'h17
// Count value on the rising edge that carries the last address bit
`define ADDR_LAST_CNT 5'h07

// Register 0 control bits
`define CTRL_ADDR 8'h00
`define SOFT_RESET_BIT 0
`define READBACK_BIT 1
`define REG_RESET_VALUE 16'h0000

// Register file depth (addresses 1..REG_COUNT-1 are stored)
`define REG_COUNT 256

`endif

// File: cfg_port_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_port_chk(input wire logic clk_sys_in, sys_rst_in, hw_reset_in, shift_clk_in,
	input wire logic serial_select_n_in, config_serial_out, config_serial_oe_out,
	input wire logic readback_mode_out, wr_strobe_out, input wire logic [7:0] wr_addr_out);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	a_oe_mode: assert property (config_serial_oe_out == readback_mode_out) else $error("oe");
	a_wr_pulse: assert property (wr_strobe_out |=> !wr_strobe_out) else $error("pulse");
	a_wr_addr: assert property (wr_strobe_out |-> wr_addr_out != 8'h00) else $error("addr");
	a_rb_nowr: assert property (wr_strobe_out |-> !readback_mode_out) else $error("rb wr");
	a_sel_nowr: assert property (serial_select_n_in [*8] |-> !wr_strobe_out)
		else $error("idle wr");
	a_out_fall: assert property (config_serial_oe_out && $past(config_serial_oe_out)
		&& $changed(config_serial_out) |-> !$past(shift_clk_in)) else $error("out rise");
	a_hw_clear: assert property (hw_reset_in [*6] |-> !readback_mode_out) else $error("hw");
	a_mode_set: assert property ($changed(readback_mode_out) && !hw_reset_in
		|-> !$past(serial_select_n_in, 6)) else $error("mode");
	c_wr: cover property (wr_strobe_out);
	c_rb: cover property (config_serial_oe_out);
	c_hw: cover property (hw_reset_in);
endmodule // cfg_port_chk
bind serial_config_port cfg_port_chk chk (.*);
`default_nettype wire

// File: cfg_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl_model(input wire logic clk_sys_in, config_serial_out,
	output logic serial_select_n_in = 1'b1, shift_clk_in = 1'b0, config_serial_in = 1'b0);
	logic [15:0] rd;
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// MSB first; caller zeroes spare bits
	task automatic xfer(input logic [63:0] w, input int n);
		serial_select_n_in = 1'b0;
		for (int i = 0; i < n; i++) begin
			config_serial_in = w[n-1-i];
			idle(5);
			shift_clk_in = 1'b1;
			// Slow clock, so read back at the rise
			rd = {rd[14:0], config_serial_out};
			idle(5);
			shift_clk_in = 1'b0;
		end
		serial_select_n_in = 1'b1;
		// Pull-down idles the line low
		config_serial_in = 1'b0;
		idle(12);
	endtask
endmodule // cfg_ctrl_model
`default_nettype wire

// File: serial_config_port_with_readback_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_with_readback_bench;
	logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, hw_reset_in = 1'b0;
	wire serial_select_n_in, shift_clk_in, config_serial_in, config_serial_out;
	wire config_serial_oe_out, readback_mode_out, wr_strobe_out;
	wire [7:0] wr_addr_out;
	wire [15:0] wr_data_out;
	int bad_count = 0, check_count = 0, writes = 0, cyc = 0;
	always #4 clk_sys_in = ~clk_sys_in;
	serial_config_port uut (.*);
	cfg_ctrl_model ctl (.*);
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_multi;
		ctl.xfer({24'h051234, 24'h05a5c3, 5'h1f}, 53);
		chk(writes, 32'h2);
		chk({wr_addr_out, wr_data_out}, 24'h05a5c3);
	endtask
	task automatic t_read;
		ctl.xfer(24'h000002, 24);
		chk(config_serial_oe_out, 1'b1);
		ctl.xfer(24'h05ffff, 24);
		chk(ctl.rd, 16'ha5c3);
		ctl.xfer(24'h000000, 24);
		chk(writes, 32'h2);
		chk(readback_mode_out, 1'b0);
	endtask
	task automatic t_reset;
		ctl.xfer(24'h000001, 24);
		ctl.idle(300);
		ctl.xfer(24'h000002, 24);
		ctl.xfer(24'h050000, 24);
		chk(ctl.rd, 16'h0000);
		hw_reset_in = 1'b1;
		ctl.idle(10);
		hw_reset_in = 1'b0;
		ctl.idle(300);
		chk(readback_mode_out, 1'b0);
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (wr_strobe_out === 1'b1)
			writes++;
		if (cyc == 10000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		ctl.idle(5);
		sys_rst_in = 1'b0;
		// Storage is swept for 256 cycles after reset
		ctl.idle(300);
		t_multi();
		t_read();
		t_reset();
		end_sim();
	end
endmodule // serial_config_port_with_readback_bench
`default_nettype wire
